// ==== inc/synth_ctrl_pkg.sv ====
`default_nettype none
package synth_ctrl_pkg;
	// ------------------------------------------------------------
	// word layout and addresses
	// ------------------------------------------------------------
	localparam int          WORD_BITS      = 32;
	localparam logic [3:0]  ADDR_REG0      = 4'h0;
	localparam logic [3:0]  ADDR_PWR       = 4'h4;
	localparam logic [3:0]  ADDR_FIXED_A   = 4'h5;
	localparam logic [3:0]  ADDR_OUT       = 4'h6;
	localparam logic [3:0]  ADDR_LOCK      = 4'h7;
	localparam logic [3:0]  ADDR_FIXED_B   = 4'h8;
	localparam logic [31:0] FIXED_A_WORD   = 32'h00800025;
	localparam logic [31:0] FIXED_B_WORD   = 32'h102D0428;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int POS_DBUF      = 14;
	localparam int POS_PDOWN     = 6;
	localparam int POS_CP_TRI    = 5;
	localparam int POS_CNT_RST   = 4;
	localparam int POS_GATED     = 30;
	localparam int POS_NEG_BLEED = 29;
	localparam int POS_FB_SRC    = 24;
	localparam int POS_DIV_LO    = 21;
	localparam int POS_BLEED_LO  = 13;
	localparam int POS_MUTE      = 11;
	localparam int POS_AUX_DIS   = 10;
	localparam int POS_PRI_EN    = 6;
	localparam int POS_PWR_LO    = 4;
	localparam int POS_LOAD_SYNC = 25;
	localparam int POS_LCNT_LO   = 8;
	localparam int POS_LOST      = 7;
	localparam int POS_PREC_LO   = 5;
	localparam int POS_WMODE     = 4;
	// ------------------------------------------------------------
	// reset values and lock timing
	// ------------------------------------------------------------
	localparam logic [31:0] RESET_WORD   = 32'h00000000;
	localparam int          CLK_PS       = 5000;
	localparam int          FIX_WIN_PS   = 2900;
	localparam int          FIX_WIN_CYC  = (FIX_WIN_PS / CLK_PS) < 1 ? 1 : FIX_WIN_PS / CLK_PS;
	localparam logic [7:0]  LOCK_COUNT0  = 8'h18;
	localparam logic [7:0]  LOCK_COUNT1  = 8'h30;
	localparam logic [7:0]  LOCK_COUNT2  = 8'h60;
	localparam logic [7:0]  LOCK_COUNT3  = 8'hC0;
	// clock cycles without a reference rise before the reference counts as lost
	localparam logic [2:0]  REF_LOSS_CYC = 3'h7;
endpackage
`default_nettype wire

// ==== inc/word_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// a committed 32-bit word from the shifter to the register bank
interface word_if;
	logic [31:0] data;
	logic        commit;
	modport source (output data, output commit);
	modport sink   (input data, input commit);
endinterface
`default_nettype wire

// ==== logic/serial_word_shifter.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_word_shifter
(
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	// serial pins, sampled on the system clock
	input  wire logic serial_clk_i,
	input  wire logic serial_data_i,
	input  wire logic load_enable_i,
	// committed word
	word_if.source    word_o
);
	import synth_ctrl_pkg::*;

	logic [31:0] shift_q;
	logic        sclk_q;
	logic        load_en_q;
	logic [31:0] data_q;
	logic        commit_q;
	wire         sclk_rise = serial_clk_i & ~sclk_q;
	wire         load_rise = load_enable_i & ~load_en_q;

	// ------------------------------------------------------------
	// msb-first shift, commit on load enable rising edge
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			shift_q  <= RESET_WORD;
			sclk_q   <= 1'b0;
			load_en_q <= 1'b0;
			data_q   <= RESET_WORD;
			commit_q <= 1'b0;
		end
		else
		begin
			sclk_q   <= serial_clk_i;
			load_en_q <= load_enable_i;
			commit_q <= load_rise;
			if (sclk_rise && !load_enable_i)
				shift_q <= {shift_q[30:0], serial_data_i};
			if (load_rise)
				data_q <= shift_q;
		end
	end

	assign word_o.data   = data_q;
	assign word_o.commit = commit_q;
endmodule
`default_nettype wire

// ==== logic/synth_control_register_bank.sv ====
// Summary of operation
// - soft power-down bit in the power register powers the synthesizer down when set.
// - power-down keeps all register contents; the serial input keeps loading words.
// - power-down loads counters, resets lock detect, tri-states pump, kills oscillator and outputs.
// - pump tristate bit puts the charge pump in high impedance.
// - counter reset bit holds reference and feedback counters and band select reset.
// - address 0110 loads the output register; host keeps its reserved bits.
// - gated bleed keeps bleed off until lock is reported.
// - negative bleed enable turns constant negative bleed on or off.
// - feedback source picks oscillator directly or the divider chain output.
// - divider select sets ratio; double buffered it waits for a register zero write.
// - eight-bit bleed level sets added bleed current.
// - mute-until-lock cuts output stage supply until lock.
// - aux output disable bit high turns the auxiliary output off.
// - primary output enable high turns the primary output on.
// - two-bit power field selects one of four primary power levels.
// - address 0111 loads the lock register; host keeps its reserved bits.
// - load-enable sync retimes the divider load to a rising reference edge.
// - lock count field sets consecutive in-window cycles before lock.
// - loss-of-lock mode makes lock detect drop lock when reference vanishes.
// - precision field selects 5, 6, 8 or 12 ns lock window.
// - lock window mode set forces a fixed 2.9 ns window.
`timescale 1ns/1ps
`default_nettype none
module synth_control_register_bank
(
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	// serial programming pins
	input  wire logic        serial_clk_i,
	input  wire logic        serial_data_i,
	input  wire logic        load_enable_i,
	// status from the analog loop and the power-down pin
	input  wire logic        reference_input_i,
	input  wire logic        phase_in_window_i,
	input  wire logic        hw_powerdown_i,
	// synthesizer controls
	output logic             powered_down_o,
	output logic             counters_load_o,
	output logic             lock_detect_reset_o,
	output logic             pump_tristate_o,
	output logic             oscillator_on_o,
	output logic             counter_reset_o,
	output logic             bleed_on_o,
	output logic             negative_bleed_o,
	output logic [7:0]       bleed_level_o,
	output logic             feedback_source_o,
	output logic [2:0]       output_divider_o,
	output logic             primary_rf_output_en_o,
	output logic             auxiliary_rf_output_en_o,
	output logic [1:0]       output_power_o,
	output logic             divider_load_o,
	output logic             lock_o,
	output logic [1:0]       lock_precision_o,
	output logic             lock_window_mode_o,
	output logic             lost_lock_mode_o,
	output logic             fixed_words_ok_o
);
	import synth_ctrl_pkg::*;

	// ------------------------------------------------------------
	// serial word capture
	// ------------------------------------------------------------
	word_if word_bus ();

	serial_word_shifter u_shifter
	(
		.ref_clk_i     (ref_clk_i),
		.reset_i       (reset_i),
		.serial_clk_i  (serial_clk_i),
		.serial_data_i (serial_data_i),
		.load_enable_i (load_enable_i),
		.word_o        (word_bus)
	);

	logic [31:0] pwr_q;
	logic [31:0] out_q;
	logic [31:0] lock_q;
	logic [31:0] fixed_a_q;
	logic [31:0] fixed_b_q;
	logic [2:0]  div_active_q;
	logic        ref_q;
	logic        load_pend_q;
	logic [7:0]  lock_cnt_q;
	logic        lock_q_int;
	logic [2:0]  ref_idle_q;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	wire [3:0] word_addr = word_bus.data[3:0];
	wire       wr_reg0   = word_bus.commit && (word_addr == ADDR_REG0);
	wire       wr_pwr    = word_bus.commit && (word_addr == ADDR_PWR);
	wire       wr_out    = word_bus.commit && (word_addr == ADDR_OUT);
	wire       wr_lock   = word_bus.commit && (word_addr == ADDR_LOCK);
	wire       wr_fix_a  = word_bus.commit && (word_addr == ADDR_FIXED_A);
	wire       wr_fix_b  = word_bus.commit && (word_addr == ADDR_FIXED_B);

	// field decode
	wire       soft_powerdown_bit     = pwr_q[POS_PDOWN];
	wire       pump_tristate_bit      = pwr_q[POS_CP_TRI];
	wire       counter_reset_bit      = pwr_q[POS_CNT_RST];
	wire       double_buffer_bit      = pwr_q[POS_DBUF];
	wire       gated_bleed_bit        = out_q[POS_GATED];
	wire       negative_bleed_enable  = out_q[POS_NEG_BLEED];
	wire       feedback_source_select = out_q[POS_FB_SRC];
	wire [2:0] output_divider_select  = out_q[POS_DIV_LO +: 3];
	wire [7:0] bleed_level_field      = out_q[POS_BLEED_LO +: 8];
	wire       mute_until_lock_bit    = out_q[POS_MUTE];
	wire       aux_output_disable     = out_q[POS_AUX_DIS];
	wire       primary_output_enable  = out_q[POS_PRI_EN];
	wire [1:0] output_power_field     = out_q[POS_PWR_LO +: 2];
	wire       load_sync_bit          = lock_q[POS_LOAD_SYNC];
	wire [1:0] lock_count_field       = lock_q[POS_LCNT_LO +: 2];
	wire       lost_lock_mode         = lock_q[POS_LOST];
	wire [1:0] lock_precision_field   = lock_q[POS_PREC_LO +: 2];
	wire       lock_window_mode_bit   = lock_q[POS_WMODE];

	// power-down from software bit or pin
	wire       pdown = soft_powerdown_bit | hw_powerdown_i;
	wire       ref_rise = reference_input_i & ~ref_q;
	wire       ref_lost = lost_lock_mode && (ref_idle_q == REF_LOSS_CYC);
	wire       lock_clear = pdown | counter_reset_bit | ref_lost;

	// lock count target per field value
	wire [7:0] lock_target = (lock_count_field == 2'h0) ? LOCK_COUNT0 :
	                         (lock_count_field == 2'h1) ? LOCK_COUNT1 :
	                         (lock_count_field == 2'h2) ? LOCK_COUNT2 : LOCK_COUNT3;
	// the window itself is measured by the analog detector; we pass the choice out
	// a commit that lands on a reference rise loads at once instead of being lost
	wire       divider_load_now = load_sync_bit ? (ref_rise && (load_pend_q || wr_reg0)) : wr_reg0;
	wire       muted = mute_until_lock_bit && !lock_q_int;

	// ------------------------------------------------------------
	// register storage; writes land even in power-down
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			pwr_q     <= RESET_WORD;
			out_q     <= RESET_WORD;
			lock_q    <= RESET_WORD;
			fixed_a_q <= RESET_WORD;
			fixed_b_q <= RESET_WORD;
		end
		else
		begin
			if (wr_pwr)
				pwr_q <= word_bus.data;
			if (wr_out)
				out_q <= word_bus.data;
			if (wr_lock)
				lock_q <= word_bus.data;
			if (wr_fix_a)
				fixed_a_q <= word_bus.data;
			if (wr_fix_b)
				fixed_b_q <= word_bus.data;
		end
	end

	// ------------------------------------------------------------
	// double-buffered divider select
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
			div_active_q <= 3'h0;
		else if (!double_buffer_bit || wr_reg0)
			div_active_q <= output_divider_select;
	end

	// ------------------------------------------------------------
	// load retiming and reference watch
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			ref_q       <= 1'b0;
			load_pend_q <= 1'b0;
			ref_idle_q  <= 3'h0;
		end
		else
		begin
			ref_q <= reference_input_i;
			if (wr_reg0 && load_sync_bit && !ref_rise)
				load_pend_q <= 1'b1;
			else if (ref_rise)
				load_pend_q <= 1'b0;
			if (ref_rise)
				ref_idle_q <= 3'h0;
			else if (ref_idle_q != REF_LOSS_CYC)
				ref_idle_q <= ref_idle_q + 3'h1;
		end
	end

	// ------------------------------------------------------------
	// digital lock detect: consecutive in-window reference cycles
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i || lock_clear)
		begin
			lock_cnt_q <= 8'h00;
			lock_q_int <= 1'b0;
		end
		else if (ref_rise)
		begin
			if (!phase_in_window_i)
				lock_cnt_q <= 8'h00;
			else if (lock_cnt_q != lock_target)
				lock_cnt_q <= lock_cnt_q + 8'h01;
			lock_q_int <= phase_in_window_i && (lock_cnt_q + 8'h01 >= lock_target);
		end
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			powered_down_o           <= 1'b0;
			counters_load_o          <= 1'b0;
			lock_detect_reset_o      <= 1'b0;
			pump_tristate_o          <= 1'b0;
			oscillator_on_o          <= 1'b1;
			counter_reset_o          <= 1'b0;
			bleed_on_o               <= 1'b0;
			negative_bleed_o         <= 1'b0;
			bleed_level_o            <= 8'h00;
			feedback_source_o        <= 1'b0;
			output_divider_o         <= 3'h0;
			primary_rf_output_en_o   <= 1'b0;
			auxiliary_rf_output_en_o <= 1'b0;
			output_power_o           <= 2'h0;
			divider_load_o           <= 1'b0;
			lock_o                   <= 1'b0;
			lock_precision_o         <= 2'h0;
			lock_window_mode_o       <= 1'b0;
			lost_lock_mode_o         <= 1'b0;
			fixed_words_ok_o         <= 1'b0;
		end
		else
		begin
			powered_down_o           <= pdown;
			counters_load_o          <= pdown;
			lock_detect_reset_o      <= pdown;
			pump_tristate_o          <= pdown | pump_tristate_bit;
			oscillator_on_o          <= !pdown;
			counter_reset_o          <= counter_reset_bit;
			bleed_on_o               <= !gated_bleed_bit || lock_q_int;
			negative_bleed_o         <= negative_bleed_enable;
			bleed_level_o            <= bleed_level_field;
			feedback_source_o        <= feedback_source_select;
			output_divider_o         <= div_active_q;
			primary_rf_output_en_o   <= primary_output_enable && !pdown && !muted;
			auxiliary_rf_output_en_o <= !aux_output_disable && !pdown && !muted;
			output_power_o           <= output_power_field;
			divider_load_o           <= divider_load_now;
			lock_o                   <= lock_q_int;
			lock_precision_o         <= lock_precision_field;
			lock_window_mode_o       <= lock_window_mode_bit;
			lost_lock_mode_o         <= lost_lock_mode;
			fixed_words_ok_o         <= (fixed_a_q == FIXED_A_WORD) && (fixed_b_q == FIXED_B_WORD);
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_pdown_write;
		wr_pwr && word_bus.data[POS_PDOWN];
	endsequence

	property p_pdown_follows;
		@(posedge ref_clk_i) disable iff (reset_i)
		s_pdown_write |=> ##1 (powered_down_o && pump_tristate_o && !oscillator_on_o);
	endproperty
	a_pdown_follows: assert property (p_pdown_follows) else $error("power-down not applied");

	property p_pdown_outputs_off;
		@(posedge ref_clk_i) disable iff (reset_i)
		$past(pdown) |-> (!primary_rf_output_en_o && !auxiliary_rf_output_en_o && counters_load_o);
	endproperty
	a_pdown_outputs_off: assert property (p_pdown_outputs_off) else $error("outputs live in power-down");

	property p_pdown_keeps_regs;
		@(posedge ref_clk_i) disable iff (reset_i)
		(pdown && !wr_out) |=> $stable(out_q);
	endproperty
	a_pdown_keeps_regs: assert property (p_pdown_keeps_regs) else $error("register lost in power-down");

	property p_tristate;
		@(posedge ref_clk_i) disable iff (reset_i)
		pump_tristate_bit |=> pump_tristate_o;
	endproperty
	a_tristate: assert property (p_tristate) else $error("pump not tristated");

	property p_counter_reset;
		@(posedge ref_clk_i) disable iff (reset_i)
		counter_reset_bit |=> (counter_reset_o && !lock_q_int);
	endproperty
	a_counter_reset: assert property (p_counter_reset) else $error("counter reset not held");

	property p_gated_bleed;
		@(posedge ref_clk_i) disable iff (reset_i)
		(gated_bleed_bit && !lock_q_int) |=> !bleed_on_o;
	endproperty
	a_gated_bleed: assert property (p_gated_bleed) else $error("bleed on before lock");

	property p_div_hold;
		@(posedge ref_clk_i) disable iff (reset_i)
		(double_buffer_bit && !wr_reg0) |=> $stable(div_active_q);
	endproperty
	a_div_hold: assert property (p_div_hold) else $error("divider changed without register zero");

	property p_mute;
		@(posedge ref_clk_i) disable iff (reset_i)
		(mute_until_lock_bit && !lock_q_int) |=> !primary_rf_output_en_o;
	endproperty
	a_mute: assert property (p_mute) else $error("output live before lock");

	property p_out_load;
		@(posedge ref_clk_i) disable iff (reset_i)
		wr_out |=> (out_q == $past(word_bus.data));
	endproperty
	a_out_load: assert property (p_out_load) else $error("output register not loaded");

	// without retiming every register zero commit loads the dividers on the next cycle
	sequence s_plain_reg0;
		wr_reg0 && !load_sync_bit;
	endsequence

	property p_plain_load;
		@(posedge ref_clk_i) disable iff (reset_i)
		s_plain_reg0 |=> divider_load_o;
	endproperty
	a_plain_load: assert property (p_plain_load) else $error("divider load missing");

	// with retiming the load never leaves between reference rising edges
	property p_sync_load;
		@(posedge ref_clk_i) disable iff (reset_i)
		(load_sync_bit && !ref_rise) |=> !divider_load_o;
	endproperty
	a_sync_load: assert property (p_sync_load) else $error("divider load off the reference edge");

	// power-down resets the lock detector and stops the oscillator one cycle later
	property p_pdown_lock_reset;
		@(posedge ref_clk_i) disable iff (reset_i)
		pdown |=> (lock_detect_reset_o && !oscillator_on_o && !lock_q_int);
	endproperty
	a_pdown_lock_reset: assert property (p_pdown_lock_reset) else $error("lock detect not reset in power-down");
endmodule
`default_nettype wire

// ==== tb/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	// clock
	input  wire logic ref_clk_i,
	// serial programming lines towards the device
	output logic      serial_clk_o,
	output logic      serial_data_o,
	output logic      load_enable_o
);
	// ------------------------------------------------
	// word shifter
	// ------------------------------------------------
	// lines idle low until the first word
	initial
	begin
		serial_clk_o  = 1'b0;
		serial_data_o = 1'b0;
		load_enable_o = 1'b0;
	end

	// hold is cycles per clock phase; 2 is the fastest legal pace
	task automatic send(input logic [31:0] word, input int hold);
		for (int i = 31; i >= 0; i--)
		begin
			@(posedge ref_clk_i);
			serial_data_o <= word[i];
			serial_clk_o  <= 1'b0;
			repeat (hold) @(posedge ref_clk_i);
			serial_clk_o <= 1'b1;
			repeat (hold - 1) @(posedge ref_clk_i);
		end
		@(posedge ref_clk_i);
		serial_clk_o  <= 1'b0;
		serial_data_o <= ~serial_data_o; // released line must not keep the last bit
		repeat (hold) @(posedge ref_clk_i);
		load_enable_o <= 1'b1;
		repeat (6) @(posedge ref_clk_i);
		load_enable_o <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
	endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	import synth_ctrl_pkg::*;
	typedef struct packed {logic [5:0] pwr; logic [16:0] outs; logic [3:0] lck; logic [6:0] misc;} note_type;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic        ref_in = 1'b0;
	logic        in_window = 1'b0;
	logic        hw_pd = 1'b0;
	logic        look = 1'b0;
	logic        s_clk, s_dat, s_load;
	logic        pd_o, cl_o, ldr_o, tri_o, osc_o, crst_o, bon_o, nb_o, fb_o, pri_o, aux_o, dl_o, lock_o, wmode_o, lost_o, ok_o;
	logic [7:0]  bl_o;
	logic [2:0]  div_o;
	logic [1:0]  pw_o, prec_o;
	logic [31:0] r4 = '0, r5 = '0, r6 = '0, r7 = '0, r8 = '0, w;
	logic [2:0]  div_act = '0;
	logic        exp_lock = 1'b0;
	int          exp_pulses = 0, seen_pulses = 0, errors = 0, comparisons = 0;
	int          seed = 32'h9fa40a8c;
	logic [7:0]  count_tab [4] = '{LOCK_COUNT0, LOCK_COUNT1, LOCK_COUNT2, LOCK_COUNT3};
	note_type    notes [$];
	note_type    seen_note;

	// clock at 200 MHz
	always #2.5 ref_clk = ~ref_clk;

	host_model host (.ref_clk_i(ref_clk), .serial_clk_o(s_clk), .serial_data_o(s_dat), .load_enable_o(s_load));

	synth_control_register_bank dut (.ref_clk_i(ref_clk), .reset_i(reset), .serial_clk_i(s_clk),
		.serial_data_i(s_dat), .load_enable_i(s_load), .reference_input_i(ref_in), .phase_in_window_i(in_window),
		.hw_powerdown_i(hw_pd), .powered_down_o(pd_o), .counters_load_o(cl_o), .lock_detect_reset_o(ldr_o),
		.pump_tristate_o(tri_o), .oscillator_on_o(osc_o), .counter_reset_o(crst_o), .bleed_on_o(bon_o),
		.negative_bleed_o(nb_o), .bleed_level_o(bl_o), .feedback_source_o(fb_o), .output_divider_o(div_o),
		.primary_rf_output_en_o(pri_o), .auxiliary_rf_output_en_o(aux_o), .output_power_o(pw_o),
		.divider_load_o(dl_o), .lock_o(lock_o), .lock_precision_o(prec_o), .lock_window_mode_o(wmode_o),
		.lost_lock_mode_o(lost_o), .fixed_words_ok_o(ok_o));

	// ------------------------------------------------
	// checking
	// ------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// expected outputs from the shadow registers
	function automatic note_type predict();
		note_type n;
		logic     pd, muted;
		pd = r4[POS_PDOWN] | hw_pd;
		muted = r6[POS_MUTE] & !exp_lock;
		n.pwr = {pd, pd, pd, pd | r4[POS_CP_TRI], !pd, r4[POS_CNT_RST]};
		n.outs = {r6[POS_NEG_BLEED], r6[20:13], r6[POS_FB_SRC], div_act, r6[POS_PRI_EN] & !pd & !muted,
			!r6[POS_AUX_DIS] & !pd & !muted, r6[5:4]};
		n.lck = {r7[6:5], r7[POS_WMODE], r7[POS_LOST]};
		n.misc = {exp_pulses[3:0], exp_lock, !r6[POS_GATED] | exp_lock, r5 === FIXED_A_WORD && r8 === FIXED_B_WORD};
		return n;
	endfunction

	// divider load pulses seen on the output
	always @(posedge ref_clk)
		if (dl_o === 1'b1)
			seen_pulses <= seen_pulses + 1;

	// oldest note against the settled outputs
	always @(posedge ref_clk)
	begin
		if (look)
		begin
			seen_note = notes.pop_front();
			check("power_ctl", {pd_o, cl_o, ldr_o, tri_o, osc_o, crst_o}, seen_note.pwr);
			check("output_ctl", {nb_o, bl_o, fb_o, div_o, pri_o, aux_o, pw_o}, seen_note.outs);
			check("lock_ctl", {prec_o, wmode_o, lost_o}, seen_note.lck);
			check("status", {seen_pulses[3:0], lock_o, bon_o, ok_o}, seen_note.misc);
		end
	end

	// ------------------------------------------------
	// stimulus
	// ------------------------------------------------
	task automatic expect_now();
		repeat (4) @(posedge ref_clk);
		notes.push_back(predict());
		look <= 1'b1;
		@(posedge ref_clk);
		look <= 1'b0;
		@(posedge ref_clk);
	endtask

	// send a word and update the shadow copy; unknown addresses change nothing
	task automatic wr(input logic [31:0] v);
		host.send(v, 2 + ($random(seed) & 1));
		if (v[3:0] == ADDR_REG0 && !r7[POS_LOAD_SYNC])
			exp_pulses++;
		if (v[3:0] == ADDR_REG0)
			div_act = r6[23:21];
		if (v[3:0] == ADDR_OUT && !r4[POS_DBUF])
			div_act = v[23:21];
		if (v[3:0] == ADDR_PWR)
			r4 = v;
		if (v[3:0] == ADDR_OUT)
			r6 = v;
		if (v[3:0] == ADDR_LOCK)
			r7 = v;
		if (v[3:0] == ADDR_FIXED_A)
			r5 = v;
		if (v[3:0] == ADDR_FIXED_B)
			r8 = v;
	endtask

	task automatic ref_rises(input int n);
		repeat (n)
		begin
			ref_in <= 1'b1;
			repeat (2) @(posedge ref_clk);
			ref_in <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
	endtask

	// reserved bits held as the host must write them
	function automatic logic [31:0] out_word(input logic [31:0] v);
		v[31] = 1'b0;
		v[28:25] = 4'b1010;
		v[12] = 1'b0;
		v[9:7] = 3'b000;
		v[3:0] = ADDR_OUT;
		return v;
	endfunction

	// f = {sync, count[1:0], loss mode, precision[1:0], window mode}
	function automatic logic [31:0] lock_word(input logic [6:0] f);
		return {6'b000100, f[6], 15'h0, f[5:0], ADDR_LOCK};
	endfunction

	task automatic conclude();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog well beyond the expected run of about 10k cycles
	initial
	begin
		#100000;
		errors++;
		conclude();
	end

	initial
	begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		expect_now();
		wr(FIXED_A_WORD);
		wr(FIXED_B_WORD ^ 32'h100);
		expect_now();
		wr(FIXED_B_WORD);
		expect_now();
		for (int k = 0; k < 8; k++)
		begin
			wr({25'h0, k[2:0], ADDR_PWR});
			expect_now();
		end
		for (int i = 0; i < 4; i++)
		begin
			w = out_word($random(seed));
			w[5:4] = i[1:0];
			wr(w);
			wr(lock_word({1'b0, i[1:0], i[1], i[1:0], i[0]}));
			expect_now();
		end
		w = $random(seed);
		w[3:0] = 4'hB;
		wr(w);
		expect_now();
		wr({25'h0, 3'b100, ADDR_PWR});
		w = out_word($random(seed));
		w[POS_PRI_EN] = 1'b1;
		w[POS_AUX_DIS] = 1'b0;
		w[POS_MUTE] = 1'b0;
		wr(w);
		expect_now();
		wr({28'h0, ADDR_PWR});
		expect_now();
		hw_pd <= 1'b1;
		expect_now();
		hw_pd <= 1'b0;
		wr({17'h0, 1'b1, 10'h0, ADDR_PWR});
		w = r6;
		w[23:21] = ~div_act;
		wr(w);
		expect_now();
		w = $random(seed);
		w[3:0] = ADDR_REG0;
		wr(w);
		expect_now();
		wr({28'h0, ADDR_PWR});
		w[POS_GATED] = 1'b1;
		w = out_word(r6 | 32'h40000840);
		wr(w);
		for (int k = 0; k < 4; k++)
		begin
			in_window <= 1'b0;
			wr({25'h0, 3'b100, ADDR_PWR});
			exp_lock = 1'b0;
			expect_now();
			wr(lock_word({1'b0, k[1:0], 4'b0110}));
			wr({28'h0, ADDR_PWR});
			in_window <= 1'b1;
			ref_rises(count_tab[k] - 2);
			expect_now();
			ref_rises(4);
			exp_lock = 1'b1;
			expect_now();
		end
		wr(lock_word(7'b0001110));
		exp_lock = 1'b0;
		expect_now();
		ref_rises(count_tab[0] + 2);
		exp_lock = 1'b1;
		expect_now();
		repeat (8) @(posedge ref_clk);
		exp_lock = 1'b0;
		expect_now();
		wr(lock_word(7'b1000110));
		w = $random(seed);
		w[3:0] = ADDR_REG0;
		wr(w);
		expect_now();
		ref_rises(1);
		exp_pulses++;
		expect_now();
		conclude();
	end
endmodule
`default_nettype wire
